/* File: uart_fifo_ctrl_irq_ident_test.sv */
// self-checking bench for the fifo control and identification block
// assumes the host model drives the register port, the bench all other inputs
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_ctrl_irq_ident_test;
	import ufcii_pkg::*;
	logic       ref_clk = 1'b0;
	logic       rstn, fc_wr, enh_func_en, ident_rd, pin_int_en;
	logic [7:0] fc_wdata, ident_rdata_r, int_enable, rd;
	logic       int_pending_r, fifo_en_r, rx_fifo_clr_r, tx_fifo_clr_r;
	logic       line_err, rx_timeout, modem_chg, pin_chg, xoff_rcvd, cts_inact, rts_inact;
	logic [6:0] rx_level, tx_space, rx_trig_r, tx_trig_r;
	int         failures, samples_checked;
	logic [6:0] rxt [4] = '{RXT_L0, RXT_L1, RXT_L2, RXT_L3};
	logic [6:0] txt [4] = '{TXT_L0, TXT_L1, TXT_L2, TXT_L3};
	logic [5:0] idc [10] = '{ID_LSR, ID_RXTO, ID_RXD, ID_TX, ID_MODEM, ID_PIN, ID_XOFF, ID_CTSRTS, ID_CTSRTS, ID_NONE};
	logic [7:0] ien [12] = '{8'h04, 8'h01, 8'h02, 8'h08, 8'h00, 8'ha0, 8'h20, 8'h40, 8'h80, 8'h20, 8'h08, 8'h0a};
	logic       pen [12] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
	logic [5:0] exc [12] = '{ID_LSR, ID_RXTO, ID_TX, ID_MODEM, ID_PIN, ID_XOFF, ID_PIN, ID_CTSRTS, ID_CTSRTS, ID_XOFF,
		ID_MODEM, ID_TX};
	ufcii_top u_ufcii_top (.ref_clk(ref_clk), .rstn(rstn), .fc_wr(fc_wr), .fc_wdata(fc_wdata),
		.enh_func_en(enh_func_en), .ident_rd(ident_rd), .ident_rdata_r(ident_rdata_r),
		.int_pending_r(int_pending_r), .int_enable(int_enable), .pin_int_en(pin_int_en),
		.line_err(line_err), .rx_timeout(rx_timeout), .modem_chg(modem_chg), .pin_chg(pin_chg),
		.xoff_rcvd(xoff_rcvd), .cts_inact(cts_inact), .rts_inact(rts_inact), .rx_level(rx_level),
		.tx_space(tx_space), .fifo_en_r(fifo_en_r), .rx_trig_r(rx_trig_r), .tx_trig_r(tx_trig_r),
		.rx_fifo_clr_r(rx_fifo_clr_r), .tx_fifo_clr_r(tx_fifo_clr_r));
	ufcii_host u_ufcii_host (.ref_clk(ref_clk), .ident_rdata_r(ident_rdata_r), .fc_wr(fc_wr),
		.fc_wdata(fc_wdata), .ident_rd(ident_rd));
	always #25 ref_clk = ~ref_clk;
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tick();
		@(posedge ref_clk);
		#2;
	endtask
	// one mask bit per source, rts last
	task automatic set_src(input logic [8:0] b);
		line_err = b[0];
		rx_timeout = b[1];
		rx_level = b[2] ? 7'h3f : 7'h00;
		tx_space = b[3] ? 7'h40 : 7'h00;
		modem_chg = b[4];
		pin_chg = b[5];
		xoff_rcvd = b[6];
		cts_inact = b[7];
		rts_inact = b[8];
	endtask
	task automatic test_reset();
		chk("fifo_en", 8'h00, {7'h00, fifo_en_r});
		chk("rx_trig", 8'h01, {1'b0, rx_trig_r});
		chk("tx_trig", 8'h40, {1'b0, tx_trig_r});
		chk("clears", 8'h00, {6'h00, rx_fifo_clr_r, tx_fifo_clr_r});
		chk("ident", IDENT_RESET, ident_rdata_r);
	endtask
	task automatic test_rx_trig();
		for (int c = 0; c < 4; c++) begin
			u_ufcii_host.write_fc({c[1:0], 6'h01});
			chk("rx_trig", {1'b0, rxt[c]}, {1'b0, rx_trig_r});
			chk("fifo_en", 8'h01, {7'h00, fifo_en_r});
			u_ufcii_host.read_ident(rd);
			chk("ident_mirror", 8'hc0, rd & 8'hc0);
		end
	endtask
	task automatic test_tx_trig();
		enh_func_en = 1'b1;
		for (int c = 0; c < 4; c++) begin
			u_ufcii_host.write_fc({2'h0, c[1:0], 4'h1});
			chk("tx_trig", {1'b0, txt[c]}, {1'b0, tx_trig_r});
		end
		enh_func_en = 1'b0;
		u_ufcii_host.write_fc(8'hc1);
		chk("tx_trig_locked", {1'b0, TXT_L3}, {1'b0, tx_trig_r});
		chk("rx_trig_taken", {1'b0, RXT_L3}, {1'b0, rx_trig_r});
	endtask
	// a clear also silences that fifo's threshold request
	task automatic test_clear();
		int_enable = 8'h03;
		set_src(9'h00c);
		u_ufcii_host.write_fc(8'h07);
		chk("clr_c1", 8'h03, {6'h00, rx_fifo_clr_r, tx_fifo_clr_r});
		chk("ident_c1", {2'h3, ID_RXD}, ident_rdata_r);
		tick();
		chk("clr_c2", 8'h03, {6'h00, rx_fifo_clr_r, tx_fifo_clr_r});
		chk("ident_c2", {2'h3, ID_NONE}, ident_rdata_r);
		tick();
		chk("clr_c3", 8'h00, {6'h00, rx_fifo_clr_r, tx_fifo_clr_r});
		chk("fifo_en", 8'h01, {7'h00, fifo_en_r});
		chk("ident_c3", {2'h3, ID_NONE}, ident_rdata_r);
		tick();
		chk("ident_c4", {2'h3, ID_RXD}, ident_rdata_r);
	endtask
	// one or two enables with every source raised, last with the time-out dropped
	task automatic test_ident_masks();
		for (int i = 0; i < 12; i++) begin
			int_enable = ien[i];
			pin_int_en = pen[i];
			set_src(9'h1ff);
			u_ufcii_host.read_ident(rd);
			chk("ident_mask", {2'h3, exc[i]}, rd);
		end
		int_enable = 8'h01;
		pin_int_en = 1'b0;
		set_src(9'h1fd);
		u_ufcii_host.read_ident(rd);
		chk("ident_rxd", {2'h3, ID_RXD}, rd);
	endtask
	// reset in mid-run while both clears run
	task automatic test_mid_reset();
		u_ufcii_host.write_fc(8'h07);
		rstn = 1'b0;
		tick();
		rstn = 1'b1;
		test_reset();
	endtask
	// drop sources from the top priority down; rx trigger 8, tx trigger 56
	task automatic test_ident();
		int_enable = 8'hef;
		pin_int_en = 1'b1;
		for (int i = 0; i < 10; i++) begin
			set_src(9'h1ff << i);
			u_ufcii_host.read_ident(rd);
			chk("ident_code", {2'h3, idc[i]}, rd);
			chk("pending", {7'h00, i < 9}, {7'h00, int_pending_r});
		end
		int_enable = 8'h00;
		pin_int_en = 1'b0;
		set_src(9'h1ff);
		u_ufcii_host.read_ident(rd);
		chk("ident_masked", {2'h3, ID_NONE}, rd);
		u_ufcii_host.write_fc(8'h00);
		u_ufcii_host.read_ident(rd);
		chk("ident_off", 8'h01, rd);
		chk("rx_trig_off", {1'b0, RXT_NOFIFO}, {1'b0, rx_trig_r});
	endtask
	task automatic stop_test();
		if (failures == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		stop_test();
	end
	initial begin
		rstn = 1'b0;
		enh_func_en = 1'b0;
		int_enable = 8'h00;
		pin_int_en = 1'b0;
		failures = 0;
		samples_checked = 0;
		set_src(9'h000);
		repeat (10) @(posedge ref_clk);
		#2;
		rstn = 1'b1;
		test_reset();
		test_rx_trig();
		test_tx_trig();
		test_clear();
		test_ident_masks();
		test_ident();
		test_mid_reset();
		stop_test();
	end
endmodule
`default_nettype wire

/* File: ufcii_clr_seq.sv */
// fifo clear sequencer: holds a clear strobe for a fixed number of cycles
// assumes start is a one-cycle pulse from logic on ref_clk
`timescale 1ns/1ps
`default_nettype none
module ufcii_clr_seq
	import ufcii_pkg::*;
#(
	parameter int CYC = CLR_CYCLES
) (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// control
	input  wire logic start,
	output logic      clr_r
);
	typedef enum logic {UFCII_IDLE, UFCII_CLEAR} ufcii_clr_e;
	localparam int CW = $clog2(CYC + 1);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);
	localparam logic [CW-1:0] CNT_MAX = CW'(CYC);

	ufcii_clr_e    st_r;
	ufcii_clr_e    st_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          clr_nxt;

	// a new start while clearing restarts the full length
	always_comb begin
		st_nxt  = st_r;
		cnt_nxt = cnt_r;
		case (st_r)
			UFCII_IDLE: begin
				if (start) begin
					st_nxt  = UFCII_CLEAR;
					cnt_nxt = CNT_ONE;
				end
			end
			UFCII_CLEAR: begin
				if (start) begin
					cnt_nxt = CNT_ONE;
				end else if (cnt_r >= CNT_MAX) begin
					st_nxt  = UFCII_IDLE;
					cnt_nxt = '0;
				end else begin
					cnt_nxt = cnt_r + CNT_ONE;
				end
			end
			default: begin
				st_nxt  = UFCII_IDLE;
				cnt_nxt = '0;
			end
		endcase
		clr_nxt = (st_nxt == UFCII_CLEAR);
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			st_r  <= UFCII_IDLE;
			cnt_r <= '0;
			clr_r <= 1'b0;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= cnt_nxt;
			clr_r <= clr_nxt;
		end
	end

	sequence s_clr_run;
		clr_r [*2];
	endsequence

	a_clr_min_len: assert property (@(posedge ref_clk) disable iff (!rstn)
		$rose(clr_r) |-> s_clr_run)
		else $error("fifo clear shorter than two cycles");
	a_clr_ends: assert property (@(posedge ref_clk) disable iff (!rstn)
		(clr_r && !start) [*2] |=> !clr_r)
		else $error("fifo clear did not end");
endmodule
`default_nettype wire

/* File: ufcii_host.sv */
// host processor model: fifo control writes and identification reads
// assumes tasks are called after reset release, strobes sampled on ref_clk
`timescale 1ns/1ps
`default_nettype none
module ufcii_host (
	// clock
	input  wire logic       ref_clk,
	// register port
	input  wire logic [7:0] ident_rdata_r,
	output var  logic       fc_wr,
	output var  logic [7:0] fc_wdata,
	output var  logic       ident_rd
);
	logic clr_wait;
	initial begin
		fc_wr = 1'b0;
		fc_wdata = 8'h00;
		ident_rd = 1'b0;
		clr_wait = 1'b0;
	end
	// register is write-only, so no read-back of it exists here
	task automatic write_fc(input logic [7:0] d);
		@(posedge ref_clk);
		#2;
		fc_wr = 1'b1;
		fc_wdata = d;
		@(posedge ref_clk);
		#2;
		fc_wr = 1'b0;
		fc_wdata = ~d;
		clr_wait = d[2] | d[1];
	endtask
	// single strobe per read, never a burst
	task automatic read_ident(output logic [7:0] d);
		if (clr_wait) begin
			repeat (2) @(posedge ref_clk);
		end
		clr_wait = 1'b0;
		@(posedge ref_clk);
		#2;
		ident_rd = 1'b1;
		@(posedge ref_clk);
		#2;
		d = ident_rdata_r;
		ident_rd = 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: ufcii_pkg.sv */
// constants for the per-channel fifo control and interrupt identification block
// assumes one clock domain and register strobes generated by the host port logic
//
// Function
// - fifo control is write-only; writes enable, clear fifos and set trigger levels.
// - receive trigger code 00/01/10/11 selects 8, 16, 56, 60 characters.
// - transmit trigger code 00/01/10/11 selects 8, 16, 32, 56 spaces.
// - transmit trigger field changes only while enhanced-function enable is set.
// - control bit 2 empties transmit fifo, spares shifter, then self-clears.
// - control bit 1 empties receive fifo, spares shifter, clears when done.
// - control bit 0 enables both fifos; reset value is disabled.
// - a fifo clear lasts at least two crystal clock cycles.
// - identification register is 8-bit read-only showing prioritised pending source.
// - identification bits 7:6 both mirror the fifo enable bit.
// - identification bit 0 is 0 while pending, 1 when nothing pending.
// - only the highest pending source is reported, priorities one to seven.
// - line status error reports code 000110 at top priority.
// - time-out 001100, receive data 000100, transmit 000010, modem 000000.
// - input pin change reports 110000 at priority five.
// - xoff or special character reports 010000 at priority six.
// - cts or rts going inactive reports 100000 at lowest priority.
package ufcii_pkg;
	// fifo control field positions
	localparam int FC_RXT_HI = 7;
	localparam int FC_RXT_LO = 6;
	localparam int FC_TXT_HI = 5;
	localparam int FC_TXT_LO = 4;
	localparam int FC_TXCLR  = 2;
	localparam int FC_RXCLR  = 1;
	localparam int FC_FEN    = 0;

	localparam logic [1:0] TRIG_RESET = 2'h0;
	localparam logic       FEN_RESET  = 1'b0;

	// trigger levels, 7-bit counts
	localparam logic [6:0] RXT_L0 = 7'h08;
	localparam logic [6:0] RXT_L1 = 7'h10;
	localparam logic [6:0] RXT_L2 = 7'h38;
	localparam logic [6:0] RXT_L3 = 7'h3c;
	localparam logic [6:0] TXT_L0 = 7'h08;
	localparam logic [6:0] TXT_L1 = 7'h10;
	localparam logic [6:0] TXT_L2 = 7'h20;
	localparam logic [6:0] TXT_L3 = 7'h38;
	// thresholds used while fifos are disabled (single holding location)
	localparam logic [6:0] RXT_NOFIFO = 7'h01;
	localparam logic [6:0] FIFO_DEPTH = 7'h40;

	// interrupt enable bit positions
	localparam int IE_RXD   = 0;
	localparam int IE_TX    = 1;
	localparam int IE_LSR   = 2;
	localparam int IE_MODEM = 3;
	localparam int IE_XOFF  = 5;
	localparam int IE_RTS   = 6;
	localparam int IE_CTS   = 7;

	// identification codes, bits 5:0
	localparam logic [5:0] ID_LSR    = 6'h06;
	localparam logic [5:0] ID_RXTO   = 6'h0c;
	localparam logic [5:0] ID_RXD    = 6'h04;
	localparam logic [5:0] ID_TX     = 6'h02;
	localparam logic [5:0] ID_MODEM  = 6'h00;
	localparam logic [5:0] ID_PIN    = 6'h30;
	localparam logic [5:0] ID_XOFF   = 6'h10;
	localparam logic [5:0] ID_CTSRTS = 6'h20;
	localparam logic [5:0] ID_NONE   = 6'h01;
	localparam logic [7:0] IDENT_RESET = 8'h01;

	// fifo clear timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int CLR_TIME_NS   = 100;
	localparam int CLR_CYCLES    = (CLR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: ufcii_top.sv */
// per-channel fifo control register and interrupt identification register
// assumes host port logic on ref_clk gives one-cycle write/read strobes and that
// fifo levels, enables and interrupt sources come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module ufcii_top
	import ufcii_pkg::*;
#(
	parameter int LW = 7
) (
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          rstn,
	// fifo control register write
	input  wire logic          fc_wr,
	input  wire logic [7:0]    fc_wdata,
	input  wire logic          enh_func_en,
	// identification register read
	input  wire logic          ident_rd,
	output logic [7:0]         ident_rdata_r,
	output logic               int_pending_r,
	// interrupt enables
	input  wire logic [7:0]    int_enable,
	input  wire logic          pin_int_en,
	// interrupt sources
	input  wire logic          line_err,
	input  wire logic          rx_timeout,
	input  wire logic          modem_chg,
	input  wire logic          pin_chg,
	input  wire logic          xoff_rcvd,
	input  wire logic          cts_inact,
	input  wire logic          rts_inact,
	// fifo state
	input  wire logic [LW-1:0] rx_level,
	input  wire logic [LW-1:0] tx_space,
	// fifo controls
	output logic               fifo_en_r,
	output logic [LW-1:0]      rx_trig_r,
	output logic [LW-1:0]      tx_trig_r,
	output logic               rx_fifo_clr_r,
	output logic               tx_fifo_clr_r
);
	logic [1:0]    rx_code_r;
	logic [1:0]    rx_code_nxt;
	logic [1:0]    tx_code_r;
	logic [1:0]    tx_code_nxt;
	logic          fifo_en_nxt;
	logic [LW-1:0] rx_trig_nxt;
	logic [LW-1:0] tx_trig_nxt;
	logic          rx_clr_go;
	logic          tx_clr_go;
	logic          rx_data_req;
	logic          tx_req;
	logic [5:0]    id_code;
	logic [7:0]    ident_nxt;
	logic          pend_nxt;

	// control register write: fields are stored, clears start sequencers
	always_comb begin
		fifo_en_nxt = fifo_en_r;
		rx_code_nxt = rx_code_r;
		tx_code_nxt = tx_code_r;
		if (fc_wr) begin
			fifo_en_nxt = fc_wdata[FC_FEN];
			rx_code_nxt = fc_wdata[FC_RXT_HI:FC_RXT_LO];
			if (enh_func_en) begin
				tx_code_nxt = fc_wdata[FC_TXT_HI:FC_TXT_LO];
			end
		end
	end

	assign rx_clr_go = fc_wr && fc_wdata[FC_RXCLR];
	assign tx_clr_go = fc_wr && fc_wdata[FC_TXCLR];

	// trigger decode; with fifos off a single location is the rx threshold, the full fifo depth the tx one
	always_comb begin
		case (rx_code_nxt)
			2'h0:    rx_trig_nxt = LW'(RXT_L0);
			2'h1:    rx_trig_nxt = LW'(RXT_L1);
			2'h2:    rx_trig_nxt = LW'(RXT_L2);
			default: rx_trig_nxt = LW'(RXT_L3);
		endcase
		case (tx_code_nxt)
			2'h0:    tx_trig_nxt = LW'(TXT_L0);
			2'h1:    tx_trig_nxt = LW'(TXT_L1);
			2'h2:    tx_trig_nxt = LW'(TXT_L2);
			default: tx_trig_nxt = LW'(TXT_L3);
		endcase
		if (!fifo_en_nxt) begin
			rx_trig_nxt = LW'(RXT_NOFIFO);
			tx_trig_nxt = LW'(FIFO_DEPTH);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			fifo_en_r <= FEN_RESET;
			rx_code_r <= TRIG_RESET;
			tx_code_r <= TRIG_RESET;
			rx_trig_r <= LW'(RXT_NOFIFO);
			tx_trig_r <= LW'(FIFO_DEPTH);
		end else begin
			fifo_en_r <= fifo_en_nxt;
			rx_code_r <= rx_code_nxt;
			tx_code_r <= tx_code_nxt;
			rx_trig_r <= rx_trig_nxt;
			tx_trig_r <= tx_trig_nxt;
		end
	end

	// clear strobes reach the fifo storage and mask the threshold requests, never the shifters
	ufcii_clr_seq #(
		.CYC(CLR_CYCLES)
	) u_rx_clr (
		.ref_clk(ref_clk),
		.rstn   (rstn),
		.start  (rx_clr_go),
		.clr_r  (rx_fifo_clr_r)
	);

	ufcii_clr_seq #(
		.CYC(CLR_CYCLES)
	) u_tx_clr (
		.ref_clk(ref_clk),
		.rstn   (rstn),
		.start  (tx_clr_go),
		.clr_r  (tx_fifo_clr_r)
	);

	// threshold requests; a fifo being cleared raises none
	assign rx_data_req = !rx_fifo_clr_r && (rx_level >= rx_trig_r);
	assign tx_req      = !tx_fifo_clr_r && (tx_space >= tx_trig_r);

	// priority encoder over enabled sources
	always_comb begin
		id_code = ID_NONE;
		if (line_err && int_enable[IE_LSR]) begin
			id_code = ID_LSR;
		end else if (rx_timeout && int_enable[IE_RXD]) begin
			id_code = ID_RXTO;
		end else if (rx_data_req && int_enable[IE_RXD]) begin
			id_code = ID_RXD;
		end else if (tx_req && int_enable[IE_TX]) begin
			id_code = ID_TX;
		end else if (modem_chg && int_enable[IE_MODEM]) begin
			id_code = ID_MODEM;
		end else if (pin_chg && pin_int_en) begin
			id_code = ID_PIN;
		end else if (xoff_rcvd && int_enable[IE_XOFF]) begin
			id_code = ID_XOFF;
		end else if ((cts_inact && int_enable[IE_CTS]) || (rts_inact && int_enable[IE_RTS])) begin
			id_code = ID_CTSRTS;
		end
		pend_nxt  = (id_code != ID_NONE);
		ident_nxt = {fifo_en_nxt, fifo_en_nxt, id_code};
	end

	// read-only: held in a register so a read always sees a settled value
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ident_rdata_r <= IDENT_RESET;
			int_pending_r <= 1'b0;
		end else begin
			ident_rdata_r <= ident_nxt;
			int_pending_r <= pend_nxt;
		end
	end

	default clocking ck @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_clr_write;
		fc_wr && fc_wdata[FC_RXCLR];
	endsequence
	sequence s_clr_held;
		rx_fifo_clr_r [*2];
	endsequence

	a_fen_write: assert property (fc_wr |=> fifo_en_r == $past(fc_wdata[FC_FEN]))
		else $error("fifo enable not taken from write");
	a_rx_clear_seq: assert property (s_clr_write |=> s_clr_held)
		else $error("receive clear not held two cycles");
	a_tx_clear_go: assert property (fc_wr && fc_wdata[FC_TXCLR] |=> tx_fifo_clr_r [*2])
		else $error("transmit clear not held two cycles");
	a_tx_clear_only: assert property (!(fc_wr && fc_wdata[FC_TXCLR]) && !tx_fifo_clr_r |=> !tx_fifo_clr_r)
		else $error("transmit clear without a write");
	a_tx_trig_lock: assert property (fc_wr && !enh_func_en |=> $stable(tx_code_r))
		else $error("transmit trigger changed while locked");
	a_rx_trig_val: assert property (fifo_en_r && rx_code_r == 2'h2 |-> rx_trig_r == LW'(RXT_L2))
		else $error("receive trigger decode wrong");
	a_tx_trig_val: assert property (fifo_en_r && tx_code_r == 2'h3 |-> tx_trig_r == LW'(TXT_L3))
		else $error("transmit trigger decode wrong");
	a_mirror_fen: assert property (ident_rdata_r[7:6] == {fifo_en_r, fifo_en_r})
		else $error("identification mirror bits wrong");
	a_status_bit: assert property (ident_rdata_r[0] == !int_pending_r)
		else $error("identification status bit wrong");
	a_lsr_top: assert property (line_err && int_enable[IE_LSR] |=> ident_rdata_r[5:0] == ID_LSR)
		else $error("line status not reported first");
	a_rxto_code: assert property (!(line_err && int_enable[IE_LSR]) && rx_timeout && int_enable[IE_RXD]
		|=> ident_rdata_r[5:0] == ID_RXTO)
		else $error("receive time-out code wrong");
	a_masked_none: assert property (int_enable == 8'h00 && !pin_int_en |=> !int_pending_r)
		else $error("masked source reported");
	a_pin_code: assert property (pin_chg && pin_int_en && int_enable == 8'h00 |=> ident_rdata_r[5:0] == ID_PIN)
		else $error("pin change code wrong");
	a_xoff_code: assert property (xoff_rcvd && int_enable == 8'h20 && !pin_int_en
		|=> ident_rdata_r[5:0] == ID_XOFF)
		else $error("xoff code wrong");
	a_cts_code: assert property (cts_inact && int_enable == 8'h80 && !pin_int_en
		|=> ident_rdata_r[5:0] == ID_CTSRTS)
		else $error("flow pin code wrong");

	// transmit clear steps mirror the receive ones
	sequence s_tx_clr_write;
		fc_wr && fc_wdata[FC_TXCLR];
	endsequence
	sequence s_tx_clr_held;
		tx_fifo_clr_r [*2];
	endsequence
	sequence s_rx_no_clr_two;
		(!(fc_wr && fc_wdata[FC_RXCLR])) [*2];
	endsequence
	sequence s_tx_no_clr_two;
		(!(fc_wr && fc_wdata[FC_TXCLR])) [*2];
	endsequence

	a_tx_clear_seq: assert property (s_tx_clr_write |=> s_tx_clr_held)
		else $error("transmit clear sequence broken");
	a_rx_clear_ends: assert property (s_clr_write ##1 s_rx_no_clr_two |=> !rx_fifo_clr_r)
		else $error("receive clear did not end");
	a_tx_clear_ends: assert property (s_tx_clr_write ##1 s_tx_no_clr_two |=> !tx_fifo_clr_r)
		else $error("transmit clear did not end");
	a_rx_clear_only: assert property (!(fc_wr && fc_wdata[FC_RXCLR]) && !rx_fifo_clr_r |=> !rx_fifo_clr_r)
		else $error("receive clear without a write");
	a_clr_quiet: assert property (rx_fifo_clr_r && tx_fifo_clr_r && int_enable == 8'h03 && !pin_int_en
		&& !rx_timeout |=> !int_pending_r)
		else $error("threshold request raised while fifos clear");

	a_rxt_write: assert property (fc_wr |=> rx_code_r == $past(fc_wdata[FC_RXT_HI:FC_RXT_LO]))
		else $error("receive trigger field not taken from write");
	a_txt_write: assert property (fc_wr && enh_func_en
		|=> tx_code_r == $past(fc_wdata[FC_TXT_HI:FC_TXT_LO]))
		else $error("transmit trigger field not taken from write");
	a_ctrl_hold: assert property (!fc_wr
		|=> $stable(fifo_en_r) && $stable(rx_code_r) && $stable(tx_code_r))
		else $error("control fields changed without a write");
	a_rx_trig_l0: assert property (fifo_en_r && rx_code_r == 2'h0 |-> rx_trig_r == LW'(RXT_L0))
		else $error("receive trigger decode wrong");
	a_rx_trig_l1: assert property (fifo_en_r && rx_code_r == 2'h1 |-> rx_trig_r == LW'(RXT_L1))
		else $error("receive trigger decode wrong");
	a_rx_trig_l3: assert property (fifo_en_r && rx_code_r == 2'h3 |-> rx_trig_r == LW'(RXT_L3))
		else $error("receive trigger decode wrong");
	a_tx_trig_l0: assert property (fifo_en_r && tx_code_r == 2'h0 |-> tx_trig_r == LW'(TXT_L0))
		else $error("transmit trigger decode wrong");
	a_tx_trig_l1: assert property (fifo_en_r && tx_code_r == 2'h1 |-> tx_trig_r == LW'(TXT_L1))
		else $error("transmit trigger decode wrong");
	a_tx_trig_l2: assert property (fifo_en_r && tx_code_r == 2'h2 |-> tx_trig_r == LW'(TXT_L2))
		else $error("transmit trigger decode wrong");
	a_trig_nofifo: assert property (!fifo_en_r
		|-> rx_trig_r == LW'(RXT_NOFIFO) && tx_trig_r == LW'(FIFO_DEPTH))
		else $error("trigger levels wrong with fifos off");

	// single and paired enables pin the code and the order
	a_rxd_code: assert property (int_enable == 8'h01 && !pin_int_en && !rx_timeout && !rx_fifo_clr_r
		&& rx_level >= rx_trig_r |=> ident_rdata_r[5:0] == ID_RXD)
		else $error("receive data code wrong");
	a_tx_code: assert property (int_enable == 8'h02 && !pin_int_en && !tx_fifo_clr_r && tx_space >= tx_trig_r
		|=> ident_rdata_r[5:0] == ID_TX)
		else $error("transmit code wrong");
	a_modem_code: assert property (int_enable == 8'h08 && !pin_int_en && modem_chg
		|=> ident_rdata_r[5:0] == ID_MODEM && int_pending_r)
		else $error("modem code wrong");
	a_rts_code: assert property (rts_inact && int_enable == 8'h40 && !pin_int_en
		|=> ident_rdata_r[5:0] == ID_CTSRTS)
		else $error("rts code wrong");
	a_modem_over_pin: assert property (modem_chg && pin_chg && pin_int_en && int_enable == 8'h08
		|=> ident_rdata_r[5:0] == ID_MODEM)
		else $error("modem not above pin change");
	a_pin_over_xoff: assert property (pin_chg && pin_int_en && xoff_rcvd && int_enable == 8'h20
		|=> ident_rdata_r[5:0] == ID_PIN)
		else $error("pin change not above xoff");
	a_xoff_over_flow: assert property (xoff_rcvd && cts_inact && int_enable == 8'ha0 && !pin_int_en
		|=> ident_rdata_r[5:0] == ID_XOFF)
		else $error("xoff not above flow pins");
	a_tx_over_modem: assert property (tx_space >= tx_trig_r && !tx_fifo_clr_r && modem_chg
		&& int_enable == 8'h0a && !pin_int_en |=> ident_rdata_r[5:0] == ID_TX)
		else $error("transmit not above modem");
	a_pend_set: assert property (line_err && int_enable[IE_LSR] |=> int_pending_r)
		else $error("pending not raised");
	a_idle_code: assert property (!int_pending_r |-> ident_rdata_r[5:0] == ID_NONE)
		else $error("idle code wrong");
	a_pin_masked: assert property (pin_chg && !pin_int_en && int_enable == 8'h00
		|=> ident_rdata_r[5:0] == ID_NONE)
		else $error("masked pin change reported");
	a_lsr_masked: assert property (line_err && !int_enable[IE_LSR]
		|=> ident_rdata_r[5:0] != ID_LSR)
		else $error("masked line status reported");
	a_rxto_masked: assert property (rx_timeout && !int_enable[IE_RXD]
		|=> ident_rdata_r[5:0] != ID_RXTO)
		else $error("masked time-out reported");
	a_xoff_masked: assert property (xoff_rcvd && !int_enable[IE_XOFF]
		|=> ident_rdata_r[5:0] != ID_XOFF)
		else $error("masked xoff reported");
endmodule
`default_nettype wire
